// >>> hw/command_source_selector.sv
// Command source selector: picks frequency and run sources from mode settings.
// Assumes AHB-Lite single word transfers, one clock hclk, async active-low reset.
// Overview of operation
// - Selection 0: hand-off-auto, auto and hand use their own sources.
// - Selection 1: a local/remote switch stops the drive.
// - Selection 2: keep running, use remote settings on any switch.
// - Selection 3: keep running, use local settings on any switch.
// - Selection 4: local settings in local, remote settings in remote.
// - Input function 41/42 overrides selections 1 to 4; standard scheme applies.
// - Nonzero selection: local uses auto sources, remote uses hand sources.
// - Local/remote enabled: auto key requests remote, hand key local.
// - Function 56 input ignored while selection is 0.
// - Function 56 with nonzero selection disables keys; input decides mode.
// - Decode hand frequency source codes 0,1,2,3,6,7,8.
// - Decode hand run source codes 0,1,2,3,5.
// - Power-up starts in auto mode with auto sources.
// - Inactive auto/hand input rejects run commands and jog.
// - Stop key gated by setting unless keypad is run source.
// - Local/remote enabled: drive local or remote keypad indication.
// - Decode auto run source codes 0,1,2,3,5.
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
module command_source_selector #(
  parameter int num_inputs = 7
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [num_inputs-1:0] multifunction_input,
  input  wire logic                  key_auto,
  input  wire logic                  key_hand,
  input  wire logic                  key_stop,
  input  wire logic                  run_request,
  input  wire logic                  jog_request,
  output logic      [7:0]            freq_source,
  output logic      [5:0]            run_source,
  output logic                       hand_mode,
  output logic                       local_indication,
  output logic                       remote_indication,
  output logic                       stop_command,
  output logic                       run_enable,
  output logic                       jog_enable
);

  // ==========================================================================
  // Decode functions
  function automatic cmd_src_pkg::freq_src_type decode_freq(input logic [3:0] code);
    case (code)
      4'h0:    decode_freq = cmd_src_pkg::freq_keypad;
      4'h1:    decode_freq = cmd_src_pkg::freq_rs485;
      4'h2:    decode_freq = cmd_src_pkg::freq_analog;
      4'h3:    decode_freq = cmd_src_pkg::freq_updown;
      4'h6:    decode_freq = cmd_src_pkg::freq_canopen;
      4'h7:    decode_freq = cmd_src_pkg::freq_dial;
      4'h8:    decode_freq = cmd_src_pkg::freq_comcard;
      default: decode_freq = cmd_src_pkg::freq_none;
    endcase
  endfunction

  function automatic cmd_src_pkg::run_src_type decode_run(input logic [3:0] code);
    case (code)
      4'h0:    decode_run = cmd_src_pkg::run_src_keypad;
      4'h1:    decode_run = cmd_src_pkg::run_src_terminal;
      4'h2:    decode_run = cmd_src_pkg::run_src_rs485;
      4'h3:    decode_run = cmd_src_pkg::run_src_canopen;
      4'h5:    decode_run = cmd_src_pkg::run_src_comcard;
      default: decode_run = cmd_src_pkg::run_src_none;
    endcase
  endfunction

  // ==========================================================================
  // Settings registers
  logic [2:0]  local_remote_select;
  logic        stop_key_gate;
  logic [3:0]  auto_freq_source;
  logic [3:0]  auto_run_source;
  logic [3:0]  hand_freq_source;
  logic [3:0]  hand_run_source;
  logic [5:0]  mi_func [num_inputs];
  logic        sw_hold;

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic        dp_write;
  logic        dp_read;
  logic [7:0]  dp_addr;
  logic        addr_valid;

  assign addr_valid = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= addr_valid && hwrite;
      dp_read  <= addr_valid && !hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_remote_select <= cmd_src_pkg::lr_sel_reset;
      stop_key_gate       <= cmd_src_pkg::stop_gate_reset;
    end else if (dp_write && dp_addr == cmd_src_pkg::off_config) begin
      local_remote_select <= hwdata[cmd_src_pkg::lr_sel_lsb +: 3];
      stop_key_gate       <= hwdata[cmd_src_pkg::stop_gate_bit];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_freq_source <= cmd_src_pkg::src_reset;
      auto_run_source  <= cmd_src_pkg::src_reset;
      hand_freq_source <= cmd_src_pkg::src_reset;
      hand_run_source  <= cmd_src_pkg::src_reset;
    end else if (dp_write && dp_addr == cmd_src_pkg::off_sources) begin
      auto_freq_source <= hwdata[cmd_src_pkg::auto_freq_lsb +: 4];
      auto_run_source  <= hwdata[cmd_src_pkg::auto_run_lsb +: 4];
      hand_freq_source <= hwdata[cmd_src_pkg::hand_freq_lsb +: 4];
      hand_run_source  <= hwdata[cmd_src_pkg::hand_run_lsb +: 4];
    end
  end

  // Drive-stop hold after a switch under selection 1; software clears it
  logic switch_stop;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_hold <= 1'b0;
    end else if (switch_stop) begin
      sw_hold <= 1'b1;
    end else if (dp_write && dp_addr == cmd_src_pkg::off_command && hwdata[0]) begin
      sw_hold <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < num_inputs; g++) begin : g_mi
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mi_func[g] <= cmd_src_pkg::mi_func_reset;
        end else if (dp_write && dp_addr == cmd_src_pkg::off_mi_func) begin
          mi_func[g] <= hwdata[g*4 +: 4] == 4'h0 ? 6'h00 :
                        hwdata[g*4 +: 4] == 4'h1 ? cmd_src_pkg::mi_fn_auto :
                        hwdata[g*4 +: 4] == 4'h2 ? cmd_src_pkg::mi_fn_hand :
                        hwdata[g*4 +: 4] == 4'h3 ? cmd_src_pkg::mi_fn_loc_rem : 6'h00;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Input synchronisation
  logic [num_inputs-1:0] mi_level;
  logic [2:0]            key_level;

  input_sync #(.width(num_inputs)) u_mi_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (multifunction_input),
    .level   (mi_level)
  );

  input_sync #(.width(3)) u_key_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({key_stop, key_hand, key_auto}),
    .level   (key_level)
  );

  // ==========================================================================
  // Terminal function decode
  logic has_ah;
  logic ah_active;
  logic hand_active;
  logic has_lr;
  logic lr_active;

  always_comb begin
    has_ah      = 1'b0;
    ah_active   = 1'b0;
    hand_active = 1'b0;
    has_lr      = 1'b0;
    lr_active   = 1'b0;
    for (int i = 0; i < num_inputs; i++) begin
      if (mi_func[i] == cmd_src_pkg::mi_fn_auto || mi_func[i] == cmd_src_pkg::mi_fn_hand) begin
        has_ah    = 1'b1;
        ah_active = ah_active | mi_level[i];
        if (mi_func[i] == cmd_src_pkg::mi_fn_hand && mi_level[i]) begin
          hand_active = 1'b1;
        end
      end
      if (mi_func[i] == cmd_src_pkg::mi_fn_loc_rem) begin
        has_lr    = 1'b1;
        lr_active = lr_active | mi_level[i];
      end
    end
  end

  // ==========================================================================
  // Mode resolution
  logic                     lr_enabled;
  logic                     key_auto_d;
  logic                     key_hand_d;
  logic                     key_stop_d;
  cmd_src_pkg::mode_type    mode;
  cmd_src_pkg::mode_type    next_mode;

  assign lr_enabled = (local_remote_select != cmd_src_pkg::lr_standard) && !has_ah;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_auto_d <= 1'b0;
      key_hand_d <= 1'b0;
      key_stop_d <= 1'b0;
    end else begin
      key_auto_d <= key_level[0];
      key_hand_d <= key_level[1];
      key_stop_d <= key_level[2];
    end
  end

  // hand_mode doubles as local in local/remote operation (remote = auto slot)
  always_comb begin
    next_mode = mode;
    if (has_ah) begin
      next_mode = hand_active ? cmd_src_pkg::mode_hand : cmd_src_pkg::mode_auto;
    end else if (lr_enabled && has_lr) begin
      next_mode = lr_active ? cmd_src_pkg::mode_auto : cmd_src_pkg::mode_hand;
    end else if (key_level[0] && !key_auto_d) begin
      next_mode = cmd_src_pkg::mode_auto;
    end else if (key_level[1] && !key_hand_d) begin
      next_mode = cmd_src_pkg::mode_hand;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= cmd_src_pkg::mode_auto;
    end else begin
      mode <= next_mode;
    end
  end

  assign switch_stop = lr_enabled && (local_remote_select == cmd_src_pkg::lr_stop)
                       && (next_mode != mode);

  // ==========================================================================
  // Source selection
  logic [3:0] sel_freq;
  logic [3:0] sel_run;
  logic       use_local;

  // Local means auto-slot settings, remote means hand-slot settings
  always_comb begin
    use_local = (mode == cmd_src_pkg::mode_hand);
    if (lr_enabled) begin
      case (local_remote_select)
        cmd_src_pkg::lr_remote_set: use_local = 1'b0;
        cmd_src_pkg::lr_local_set:  use_local = 1'b1;
        default:                    use_local = (mode == cmd_src_pkg::mode_hand);
      endcase
      sel_freq = use_local ? auto_freq_source : hand_freq_source;
      sel_run  = use_local ? auto_run_source : hand_run_source;
    end else begin
      sel_freq = (mode == cmd_src_pkg::mode_hand) ? hand_freq_source : auto_freq_source;
      sel_run  = (mode == cmd_src_pkg::mode_hand) ? hand_run_source : auto_run_source;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_source       <= cmd_src_pkg::freq_keypad;
      run_source        <= cmd_src_pkg::run_src_keypad;
      hand_mode         <= 1'b0;
      local_indication  <= 1'b0;
      remote_indication <= 1'b0;
    end else begin
      freq_source       <= decode_freq(sel_freq);
      run_source        <= decode_run(sel_run);
      hand_mode         <= (next_mode == cmd_src_pkg::mode_hand);
      local_indication  <= lr_enabled && next_mode == cmd_src_pkg::mode_hand;
      remote_indication <= lr_enabled && next_mode == cmd_src_pkg::mode_auto;
    end
  end

  // ==========================================================================
  // Run gating and stop key
  logic blocked;
  assign blocked = (has_ah && !ah_active) || sw_hold;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_enable   <= 1'b0;
      jog_enable   <= 1'b0;
      stop_command <= 1'b0;
    end else begin
      run_enable   <= run_request && !blocked;
      jog_enable   <= jog_request && !blocked;
      stop_command <= switch_stop || (key_level[2] && !key_stop_d &&
                      (sel_run == cmd_src_pkg::run_keypad || stop_key_gate));
    end
  end

  // ==========================================================================
  // Read mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      case (haddr[7:0])
        cmd_src_pkg::off_config:  hrdata <= {27'h0, stop_key_gate, 1'b0, local_remote_select};
        cmd_src_pkg::off_sources: hrdata <= {16'h0, hand_run_source, hand_freq_source,
                                             auto_run_source, auto_freq_source};
        cmd_src_pkg::off_status:  hrdata <= {24'h0, sw_hold, local_indication,
                                             remote_indication, hand_mode, 2'h0,
                                             has_lr, has_ah};
        default:                  hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> hw/cmd_src_pkg.sv
// Package for the command source selector: register map, field codes, reset values.
// Assumes a 32-bit AHB-Lite register bus and a 25 MHz system clock.
package cmd_src_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] off_config   = 8'h00;
  localparam logic [7:0] off_sources  = 8'h04;
  localparam logic [7:0] off_mi_func  = 8'h08;
  localparam logic [7:0] off_command  = 8'h0c;
  localparam logic [7:0] off_status   = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int lr_sel_lsb       = 0;
  localparam int stop_gate_bit    = 4;
  localparam int auto_freq_lsb    = 0;
  localparam int auto_run_lsb     = 4;
  localparam int hand_freq_lsb    = 8;
  localparam int hand_run_lsb     = 12;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] lr_sel_reset    = 3'h0;
  localparam logic       stop_gate_reset = 1'b0;
  localparam logic [3:0] src_reset       = 4'h0;
  localparam logic [5:0] mi_func_reset   = 6'h00;

  // ==========================================================================
  // Local/remote selection codes
  localparam logic [2:0] lr_standard   = 3'h0;
  localparam logic [2:0] lr_stop       = 3'h1;
  localparam logic [2:0] lr_remote_set = 3'h2;
  localparam logic [2:0] lr_local_set  = 3'h3;
  localparam logic [2:0] lr_follow     = 3'h4;

  // Multi-function input function codes
  localparam logic [5:0] mi_fn_auto    = 6'h29;
  localparam logic [5:0] mi_fn_hand    = 6'h2a;
  localparam logic [5:0] mi_fn_loc_rem = 6'h38;

  // Run source codes
  localparam logic [3:0] run_keypad = 4'h0;

  // Decoded frequency sources, one-hot
  typedef enum logic [7:0] {
    freq_keypad   = 8'h01,
    freq_rs485    = 8'h02,
    freq_analog   = 8'h04,
    freq_updown   = 8'h08,
    freq_canopen  = 8'h10,
    freq_dial     = 8'h20,
    freq_comcard  = 8'h40,
    freq_none     = 8'h80
  } freq_src_type;

  // Decoded run sources, one-hot
  typedef enum logic [5:0] {
    run_src_keypad   = 6'h01,
    run_src_terminal = 6'h02,
    run_src_rs485    = 6'h04,
    run_src_canopen  = 6'h08,
    run_src_comcard  = 6'h10,
    run_src_none     = 6'h20
  } run_src_type;

  // Operating mode, Gray order
  typedef enum logic [1:0] {
    mode_auto = 2'b00,
    mode_hand = 2'b01
  } mode_type;

endpackage

// >>> hw/input_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs asynchronous to hclk.
module input_sync #(
  parameter int width = 4
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [width-1:0] pin,
  output logic      [width-1:0] level
);

  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Change counts once second and third stage agree
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          level[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  endgenerate

endmodule

// >>> verification/cmd_src_checker.sv
// Checker for the command source selector output relations.
// Bound to command_source_selector; sees only its ports.
module cmd_src_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        run_request,
  input wire logic        jog_request,
  input wire logic [7:0]  freq_source,
  input wire logic [5:0]  run_source,
  input wire logic        hand_mode,
  input wire logic        local_indication,
  input wire logic        remote_indication,
  input wire logic        stop_command,
  input wire logic        run_enable,
  input wire logic        jog_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================
  // Assertions
  a_freq_onehot: assert property ($onehot(freq_source))
    else $error("frequency source not one-hot");
  a_run_onehot: assert property ($onehot(run_source))
    else $error("run source not one-hot");
  a_ind_exclusive: assert property (!(local_indication && remote_indication))
    else $error("local and remote shown together");
  a_local_hand: assert property (local_indication |-> hand_mode)
    else $error("local shown outside hand mode");
  a_remote_auto: assert property (remote_indication |-> !hand_mode)
    else $error("remote shown in hand mode");
  a_run_gate: assert property (run_enable |-> $past(run_request))
    else $error("run enabled without request");
  a_jog_gate: assert property (jog_enable |-> $past(jog_request))
    else $error("jog enabled without request");
  a_stop_pulse: assert property (stop_command |=> !stop_command)
    else $error("stop command longer than one cycle");
  a_read_hold: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");
  // ==========================================
  // Coverage
  c_stop: cover property (stop_command);
  c_local: cover property (local_indication);
  c_remote: cover property (remote_indication);
endmodule

bind command_source_selector cmd_src_checker i_cmd_src_checker (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .run_request,
  .jog_request, .freq_source, .run_source, .hand_mode, .local_indication,
  .remote_indication, .stop_command, .run_enable, .jog_enable);

// >>> verification/far_model.sv
// Far-side model: keypad keys, input terminals and run/jog requests.
// Assumes the bench calls its tasks; every change follows a rising edge.
module far_model #(
  parameter int n = 7
) (
  input  wire logic    hclk,
  output logic         key_auto,
  output logic         key_hand,
  output logic         key_stop,
  output logic [n-1:0] multifunction_input,
  output logic         run_request,
  output logic         jog_request
);
  initial begin
    key_auto = 1'b0;
    key_hand = 1'b0;
    key_stop = 1'b0;
    multifunction_input = '0;
    run_request = 1'b0;
    jog_request = 1'b0;
  end
  // Key held long enough to pass the input filter, then released low
  task automatic press(input int k);
    @(posedge hclk);
    key_auto <= (k == 0);
    key_hand <= (k == 1);
    key_stop <= (k == 2);
    repeat (8) @(posedge hclk);
    key_auto <= 1'b0;
    key_hand <= 1'b0;
    key_stop <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
  task automatic term(input int i, input logic v);
    @(posedge hclk);
    multifunction_input[i] <= v;
    repeat (10) @(posedge hclk);
  endtask
  task automatic req(input logic r, input logic j);
    @(posedge hclk);
    run_request <= r;
    jog_request <= j;
    repeat (3) @(posedge hclk);
  endtask
endmodule

// >>> verification/command_source_selector_tb.sv
// Self-checking bench for the command source selector.
// Assumes far_model drives keys and terminals; bus master is this bench.
module command_source_selector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [6:0]  multifunction_input;
  logic        key_auto, key_hand, key_stop, run_request, jog_request;
  logic [7:0]  freq_source;
  logic [5:0]  run_source;
  logic        hand_mode, local_indication, remote_indication;
  logic        stop_command, run_enable, jog_enable;
  int          error_cnt, total_checks, cycles, stop_cnt;
  logic [31:0] rd;
  localparam logic [7:0] ftab [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80,
                                       8'h80, 8'h10, 8'h20, 8'h40, 8'h80};
  localparam logic [5:0] rtab [10] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h20,
                                       6'h10, 6'h20, 6'h20, 6'h20, 6'h20};
  assign hready = hreadyout;
  command_source_selector i_command_source_selector (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .multifunction_input, .key_auto, .key_hand,
    .key_stop, .run_request, .jog_request, .freq_source, .run_source, .hand_mode,
    .local_indication, .remote_indication, .stop_command, .run_enable, .jog_enable);
  far_model i_far_model (
    .hclk, .key_auto, .key_hand, .key_stop, .multifunction_input, .run_request,
    .jog_request);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    stop_cnt <= stop_cnt + (stop_command === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (3) @(posedge hclk);
  endtask
  function automatic logic [31:0] st(logic h, l, r, logic [7:0] f, logic [5:0] s);
    return {15'h0000, h, l, r, f, s};
  endfunction
  task automatic cko(input logic [31:0] e);
    chk("outputs", e, st(hand_mode, local_indication, remote_indication,
                         freq_source, run_source));
  endtask
  task automatic cken(input logic [1:0] e);
    chk("enables", {30'h0, e}, {30'h0, run_enable, jog_enable});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    cko(st(1'b0, 1'b0, 1'b0, 8'h01, 6'h01));
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b0, 8'h00, 32'h0);
    chk("config", 32'h0, rd);
    wr(8'h20, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_decode();
    logic [3:0] k, a;
    for (int c = 0; c < 10; c++) begin
      k = c[3:0];
      a = 4'(9 - c);
      wr(8'h04, {16'h0000, k, k, a, a});
      cko(st(1'b0, 1'b0, 1'b0, ftab[a], rtab[a]));
      i_far_model.press(1);
      cko(st(1'b1, 1'b0, 1'b0, ftab[k], rtab[k]));
      i_far_model.press(0);
    end
  endtask
  task automatic step(input logic [2:0] lr, input int key, input logic [31:0] e);
    wr(8'h00, {29'h0, lr});
    i_far_model.press(key);
    cko(e);
  endtask
  task automatic t_locrem();
    wr(8'h04, 32'h2211);
    step(3'h4, 1, st(1'b1, 1'b1, 1'b0, 8'h02, 6'h02));
    step(3'h4, 0, st(1'b0, 1'b0, 1'b1, 8'h04, 6'h04));
    step(3'h2, 1, st(1'b1, 1'b1, 1'b0, 8'h04, 6'h04));
    step(3'h3, 0, st(1'b0, 1'b0, 1'b1, 8'h02, 6'h02));
  endtask
  task automatic t_switch_stop();
    int n;
    wr(8'h00, 32'h1);
    i_far_model.req(1'b1, 1'b0);
    cken(2'b10);
    n = stop_cnt;
    i_far_model.press(1);
    chk("stops", n + 1, stop_cnt);
    cken(2'b00);
    bus(1'b0, 8'h10, 32'h0);
    chk("status", 32'hd0, rd);
    wr(8'h0c, 32'h1);
    cken(2'b10);
    i_far_model.req(1'b0, 1'b0);
  endtask
  task automatic t_auto_hand_term();
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h0032_1000);
    i_far_model.req(1'b1, 1'b1);
    cken(2'b00);
    i_far_model.term(4, 1'b1);
    chk("hand_freq", 32'h104, {23'h0, hand_mode, freq_source});
    cken(2'b11);
    i_far_model.term(5, 1'b1);
    chk("hand_freq", 32'h104, {23'h0, hand_mode, freq_source});
    i_far_model.term(5, 1'b0);
    i_far_model.term(4, 1'b0);
    i_far_model.term(3, 1'b1);
    chk("hand_freq", 32'h002, {23'h0, hand_mode, freq_source});
    i_far_model.term(3, 1'b0);
    i_far_model.req(1'b0, 1'b0);
    wr(8'h08, 32'h0);
  endtask
  task automatic t_locrem_term();
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0300_0000);
    i_far_model.press(1);
    i_far_model.term(6, 1'b1);
    cko(st(1'b1, 1'b0, 1'b0, 8'h04, 6'h04));
    wr(8'h00, 32'h4);
    cko(st(1'b0, 1'b0, 1'b1, 8'h04, 6'h04));
    i_far_model.press(1);
    cko(st(1'b0, 1'b0, 1'b1, 8'h04, 6'h04));
    i_far_model.term(6, 1'b0);
    cko(st(1'b1, 1'b1, 1'b0, 8'h02, 6'h02));
    wr(8'h08, 32'h0);
  endtask
  task automatic sk(input logic [31:0] cfg, input logic [31:0] src, input int e);
    int n;
    wr(8'h00, cfg);
    wr(8'h04, src);
    n = stop_cnt;
    i_far_model.press(2);
    chk("stops", n + e, stop_cnt);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    error_cnt = 0;
    total_checks = 0;
    cycles = 0;
    stop_cnt = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_decode();
    t_locrem();
    t_switch_stop();
    t_auto_hand_term();
    t_locrem_term();
    i_far_model.press(0);
    sk(32'h00, 32'h00, 1);
    sk(32'h00, 32'h10, 0);
    sk(32'h10, 32'h10, 1);
    sk(32'h10, 32'h00, 1);
    conclude();
  end
endmodule
